// ### hw/serial_rx_auto_wakeup.sv
// Auto-wake-up sequencer for an asynchronous serial receiver
// Summary of operation
// R1: Setting wake-up enable holds receiver idle, only watching the receive line.
// R2: Wake-up event while armed sets receive interrupt flag before enable clears.
// R3: First rising receive line edge after wake-up clears enable, resumes reception.
// R4: Reading the receive data register clears the receive interrupt flag.
// R5: Software discards the byte read after a wake-up as dummy data.
// R6: Any rising edge before stop bit ends the break; may cause errors.
// R7: Remote sends all-zero first character: 00h, or 12-bit 000h for LIN.
// R8: Remote break and gap must cover oscillator start and receiver init.
// R9: Software checks data integrity separately, not via enable or flag.
// R10: Software checks receive idle flag before arming just prior to sleep.
// R11: Falling receive line edge while armed is the wake-up event.
`timescale 1ns/1ns
`default_nettype none
module serial_rx_auto_wakeup (
  input  wire  logic                      clk,
  input  wire  logic                      reset,
  input  wire  logic                      clkEnable,
  input  wire  logic                      receiveLinePin,
  input  wire  wake_pkg::soft_ctrl_type   softCtrl,
  output var   wake_pkg::wake_status_type status,
  output logic                            wakeEvent
);

  // Sequencer state
  wake_pkg::wake_state_type state_reg;
  wake_pkg::wake_state_type state_next;
  // Previous receive line sample
  logic                     line_reg;
  logic                     line_next;
  // Receive interrupt flag
  logic                     flag_reg;
  logic                     flag_next;
  // Receive idle status
  logic                     idle_reg;
  logic                     idle_next;
  // Wake-up event pulse
  logic                     event_reg;
  logic                     event_next;
  // Registered copies of the state decode
  logic                     enable_reg;
  logic                     enable_next;
  logic                     held_reg;
  logic                     held_next;
  // Line edges and state decodes
  logic                     fallEdge;
  logic                     riseEdge;
  logic                     normalNow;
  logic                     armedNow;
  logic                     breakNow;
  logic                     wakeSeen;
  logic                     exitSeen;
  logic                     flagSetNow;

  // True while the receiver is kept out of normal reception
  function automatic logic isHeld(
    input wake_pkg::wake_state_type st
  );
    return st != wake_pkg::STATE_NORMAL;
  endfunction

  // High-to-low step between two line samples
  function automatic logic fallOf(
    input logic prev, input logic now
  );
    return prev & ~now;
  endfunction

  // Low-to-high step between two line samples
  function automatic logic riseOf(
    input logic prev, input logic now
  );
    return ~prev & now;
  endfunction

  // Line edges against the previous registered sample
  assign fallEdge = fallOf(line_reg, receiveLinePin); // R11
  assign riseEdge = riseOf(line_reg, receiveLinePin); // R3

  // Current state decodes and qualified events
  assign normalNow  = (state_reg == wake_pkg::STATE_NORMAL);
  assign armedNow   = (state_reg == wake_pkg::STATE_ARMED);
  assign breakNow   = (state_reg == wake_pkg::STATE_BREAK);
  assign wakeSeen   = armedNow & fallEdge; // R2 R11
  assign exitSeen   = breakNow & riseEdge; // R3 R6
  assign flagSetNow = wakeSeen | (normalNow & softCtrl.rxFlagSet); // R1 R2

  // Line sample follows the pin
  always_comb begin
    line_next = receiveLinePin;
  end

  // Line sample register, idle high after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      line_reg <= wake_pkg::RESET_LINE;
    end else if (clkEnable) begin
      line_reg <= line_next;
    end
  end

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      wake_pkg::STATE_NORMAL: begin
        if (softCtrl.armRequest) begin
          state_next = wake_pkg::STATE_ARMED; // R1
        end
      end
      wake_pkg::STATE_ARMED: begin
        if (wakeSeen) begin
          state_next = wake_pkg::STATE_BREAK; // R11
        end
      end
      wake_pkg::STATE_BREAK: begin
        if (exitSeen) begin
          state_next = wake_pkg::STATE_NORMAL; // R3 R6
        end
      end
      default: begin
        state_next = wake_pkg::STATE_NORMAL;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= wake_pkg::STATE_NORMAL;
    end else if (clkEnable) begin
      state_reg <= state_next;
    end
  end

  // Wake-up pulse for one enabled cycle
  always_comb begin
    event_next = 1'b0;
    if (wakeSeen) begin
      event_next = 1'b1; // R2
    end
  end

  // Wake-up pulse register
  always_ff @(posedge clk) begin
    if (reset) begin
      event_reg <= wake_pkg::RESET_EVENT;
    end else if (clkEnable) begin
      event_reg <= event_next;
    end
  end

  // Receive interrupt flag, a set beats a read in the same cycle
  always_comb begin
    flag_next = flag_reg;
    if (softCtrl.dataRead) begin
      flag_next = 1'b0; // R4
    end
    if (flagSetNow) begin
      flag_next = 1'b1; // R2
    end
  end

  // Receive interrupt flag register
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_reg <= wake_pkg::RESET_FLAG;
    end else if (clkEnable) begin
      flag_reg <= flag_next;
    end
  end

  // Idle status forced while the receiver is held
  always_comb begin
    idle_next = softCtrl.rxIdle;
    if (isHeld(state_next)) begin
      idle_next = 1'b1; // R1
    end
  end

  // Idle status register
  always_ff @(posedge clk) begin
    if (reset) begin
      idle_reg <= wake_pkg::RESET_IDLE;
    end else if (clkEnable) begin
      idle_reg <= idle_next;
    end
  end

  // Wake-up enable follows the next state
  always_comb begin
    enable_next = isHeld(state_next); // R1 R3
  end

  // Wake-up enable register
  always_ff @(posedge clk) begin
    if (reset) begin
      enable_reg <= wake_pkg::RESET_WAKE_ENABLE;
    end else if (clkEnable) begin
      enable_reg <= enable_next;
    end
  end

  // Receiver hold follows the next state
  always_comb begin
    held_next = isHeld(state_next); // R1
  end

  // Receiver hold register
  always_ff @(posedge clk) begin
    if (reset) begin
      held_reg <= wake_pkg::RESET_WAKE_ENABLE;
    end else if (clkEnable) begin
      held_reg <= held_next;
    end
  end

  // Outputs straight from flip-flops
  assign status.wakeUpEnable         = enable_reg;
  assign status.receiveInterruptFlag = flag_reg;
  assign status.receiveIdleFlag      = idle_reg;
  assign status.receiverHeld         = held_reg; // R1
  assign wakeEvent                   = event_reg;

endmodule // serial_rx_auto_wakeup
`default_nettype wire

// ### hw/wake_pkg.sv
// Package with states and carrier types for the serial receiver wake-up logic
package wake_pkg;
  // Reset values
  localparam logic RESET_WAKE_ENABLE = 1'b0;
  localparam logic RESET_FLAG        = 1'b0;
  localparam logic RESET_LINE        = 1'b1;
  localparam logic RESET_IDLE        = 1'b1;
  localparam logic RESET_EVENT       = 1'b0;

  // Wake-up sequencer states
  typedef enum logic [1:0] {
    STATE_NORMAL = 2'b00,
    STATE_ARMED  = 2'b01,
    STATE_BREAK  = 2'b10
  } wake_state_type;

  // Software-side controls
  typedef struct packed {
    logic armRequest;   // Pulse: set the wake-up enable
    logic dataRead;     // Pulse: software reads receive data register
    logic rxFlagSet;    // Pulse: normal receiver delivered a byte
    logic rxIdle;       // Level: normal receiver idle
  } soft_ctrl_type;

  // Status seen by software
  typedef struct packed {
    logic wakeUpEnable;
    logic receiveInterruptFlag;
    logic receiveIdleFlag;
    logic receiverHeld;
  } wake_status_type;
endpackage : wake_pkg

// ### test/remote_node.sv
// Remote serial node sending all-zero breaks
`timescale 1ns/1ns
`default_nettype none
module remote_node (
  input wire logic       clk,
  input wire logic       go,
  input wire logic [7:0] len,
  output logic           line
);
  logic [7:0] cnt = 8'h00;
  // Line low for len cycles, idle high
  assign line = cnt == 8'h00;
  always @(posedge clk) cnt <= go ? len : cnt - 8'(cnt != 8'h00);
endmodule // remote_node
`default_nettype wire

// ### test/serial_rx_auto_wakeup_bench.sv
// Randomised bench with a cycle model of the sequencer
`timescale 1ns/1ns
`default_nettype none
module serial_rx_auto_wakeup_bench;
  logic clk = 1'b0, reset = 1'b1, go = 1'b0, ev = 1'b0, fl = 1'b0, lp = 1'b1, line, we;
  logic ce = 1'b1, id = 1'b1, idleBit = 1'b1;
  logic [7:0] len = 8'h01;
  wake_pkg::soft_ctrl_type   sc = '0;
  wake_pkg::wake_status_type st;
  int miscompares = 0, checks = 0, s = 0;
  always #5 clk = ~clk;
  remote_node i_remote_node (.clk(clk), .go(go), .len(len), .line(line));
  serial_rx_auto_wakeup i_serial_rx_auto_wakeup (.clk(clk), .reset(reset), .clkEnable(ce),
    .receiveLinePin(line), .softCtrl(sc), .status(st), .wakeEvent(we));
  task automatic chk(input string n, input logic v, input logic e);
    checks++;
    if (v !== e) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", n, e, v);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Reference model, compared at every edge out of reset
  always @(posedge clk) begin
    if (!reset) begin
      chk("enable", st.wakeUpEnable, s != 0);
      chk("held", st.receiverHeld, s != 0);
      chk("flag", st.receiveInterruptFlag, fl);
      chk("idle", st.receiveIdleFlag, id);
      chk("event", we, ev);
    end
    // Model holds its state while the clock enable is low
    if (reset) begin
      ev = 1'b0;
      fl = 1'b0;
      s = 0;
      id = 1'b1;
      lp = 1'b1;
    end else if (ce) begin
      ev = s == 1 && lp && !line;
      fl = ev || (s == 0 && sc.rxFlagSet) || (fl && !sc.dataRead);
      s = s == 0 ? int'(sc.armRequest) : s == 1 ? (ev ? 2 : 1) : (!lp && line ? 0 : 2);
      id = s != 0 || sc.rxIdle;
      lp = line;
    end
  end
  // Random traffic and breaks
  initial begin
    void'($urandom(32'hf69e4520));
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    // Random clock enable and a reset in mid-run
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1 reset = i >= 1500 && i < 1502;
      ce = $urandom % 5 != 0;
      idleBit = 1'($urandom);
      sc.rxIdle = idleBit;
      sc.armRequest = idleBit && $urandom % 8 == 0;
      sc.dataRead = $urandom % 6 == 0;
      sc.rxFlagSet = $urandom % 4 == 0;
      go = line && $urandom % 12 == 0;
      len = 8'($urandom % 9 + 1);
    end
    stop_test;
  end
  initial begin
    #40000 miscompares++;
    stop_test;
  end
endmodule // serial_rx_auto_wakeup_bench
`default_nettype wire

// ### test/wake_check_sva.sv
// Checker for the wake-up sequencer ports
`timescale 1ns/1ns
`default_nettype none
module wake_check (
  input wire logic                      clk,
  input wire logic                      reset,
  input wire logic                      clkEnable,
  input wire logic                      receiveLinePin,
  input wire wake_pkg::soft_ctrl_type   softCtrl,
  input wire wake_pkg::wake_status_type status,
  input wire logic                      wakeEvent
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Arming and holding
  a_arm_sets: assert property (
    clkEnable && softCtrl.armRequest && !status.wakeUpEnable
    |=> status.wakeUpEnable && status.receiverHeld)
    else $error("arm lost");
  a_idle_forced: assert property (
    status.wakeUpEnable |-> status.receiveIdleFlag && status.receiverHeld)
    else $error("idle not forced");
  a_rx_refused: assert property (
    status.wakeUpEnable && softCtrl.rxFlagSet && receiveLinePin
    && !status.receiveInterruptFlag
    |=> !status.receiveInterruptFlag)
    else $error("rx while armed");
  // Wake event, exit and flag read
  a_wake_flag: assert property (
    clkEnable && $past(clkEnable) && status.wakeUpEnable && $fell(receiveLinePin)
    |=> wakeEvent && status.receiveInterruptFlag)
    else $error("no wake");
  a_flag_first: assert property (
    wakeEvent |-> status.wakeUpEnable && status.receiveInterruptFlag)
    else $error("flag late");
  a_low_keeps: assert property (
    status.wakeUpEnable && !receiveLinePin |=> status.wakeUpEnable)
    else $error("early clear");
  a_rise_clears: assert property (
    clkEnable && wakeEvent && receiveLinePin |=> !status.wakeUpEnable)
    else $error("no clear");
  a_read_clears: assert property (
    clkEnable && softCtrl.dataRead && !softCtrl.rxFlagSet && !status.wakeUpEnable
    |=> !status.receiveInterruptFlag)
    else $error("flag kept");
  // Main scenarios
  c_wake: cover property (wakeEvent);
  c_exit: cover property ($fell(status.wakeUpEnable));
  c_read: cover property (softCtrl.dataRead && status.receiveInterruptFlag);
endmodule // wake_check
bind serial_rx_auto_wakeup wake_check i_wake_check (.*);
`default_nettype wire
